// *** rtl/psm_pkg.sv ***
// Package of constants and types for the processor state and mode controller.
package psm_pkg;
  localparam logic [31:0] PSM_RESET_VECTOR = 32'ha0000000;
  localparam int          PSM_MD_BIT       = 30;
  localparam logic        PSM_MD_USER      = 1'b0;
  localparam logic        PSM_MD_PRIV      = 1'b1;
  localparam logic [31:0] PSM_SR_RST       = 32'h700000f0;
  localparam logic [31:0] PSM_VBR_RST      = 32'h00000000;

  typedef enum logic [4:0] {
    PSM_ST_RESET = 5'h01,
    PSM_ST_EXC   = 5'h02,
    PSM_ST_RUN   = 5'h04,
    PSM_ST_BUSRL = 5'h08,
    PSM_ST_PDN   = 5'h10
  } psm_state_t;

  typedef enum logic [1:0] {
    PSM_RST_NONE   = 2'h0,
    PSM_RST_POWER  = 2'h1,
    PSM_RST_MANUAL = 2'h2
  } psm_rst_kind_t;
endpackage

// *** rtl/psm_reset_arb.sv ***
// Reset source arbiter that classifies the two reset pins.
module psm_reset_arb
  import psm_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_power_on_reset_n,
  input  wire logic          i_manual_reset_n,
  output psm_rst_kind_t      o_kind,
  output logic               o_init_bsc
);
  psm_rst_kind_t kind_nxt;

  always_comb begin
    kind_nxt = PSM_RST_NONE;
    if (!i_power_on_reset_n) begin
      kind_nxt = PSM_RST_POWER; // [RQ1] [RQ16]
    end else if (!i_manual_reset_n) begin
      kind_nxt = PSM_RST_MANUAL; // [RQ2]
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_kind <= PSM_RST_POWER;
    end else begin
      o_kind <= kind_nxt;
    end
  end

  // Bus controller state survives a manual reset so external memory stays refreshed.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_init_bsc <= 1'b1;
    end else begin
      o_init_bsc <= (kind_nxt == PSM_RST_POWER); // [RQ3] [RQ4]
    end
  end

  AST_POWER_WINS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_power_on_reset_n && !i_manual_reset_n) |=> o_kind == PSM_RST_POWER) // [RQ16]
    else $error("power-on reset did not take priority");
endmodule // psm_reset_arb

// *** rtl/psm_pc_unit.sv ***
// Program counter and saved context registers.
module psm_pc_unit
  import psm_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_in_reset,
  input  wire logic          i_exc_take,
  input  wire logic          i_rst_leave,
  input  wire logic          i_step,
  input  wire logic          i_branch,
  input  wire logic [31:0]   i_branch_addr,
  input  wire logic [31:0]   i_vbr,
  input  wire logic [31:0]   i_vec_offset,
  input  wire logic [31:0]   i_status,
  input  wire logic          i_rte,
  output logic      [31:0]   o_pc,
  output logic      [31:0]   o_saved_pc,
  output logic      [31:0]   o_saved_status_word
);
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_in_reset || i_rst_leave) begin
      o_pc <= PSM_RESET_VECTOR; // [RQ5]
    end else if (i_exc_take) begin
      o_pc <= i_vbr + i_vec_offset; // [RQ7]
    end else if (i_rte) begin
      o_pc <= o_saved_pc;
    end else if (i_branch) begin
      o_pc <= i_branch_addr;
    end else if (i_step) begin
      o_pc <= o_pc + 32'h00000002; // [RQ15]
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_saved_pc          <= 32'h00000000;
      o_saved_status_word <= 32'h00000000;
    end else if (i_exc_take) begin
      o_saved_pc          <= o_pc; // [RQ6]
      o_saved_status_word <= i_status; // [RQ6]
    end
  end

  AST_VECTOR_BRANCH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_exc_take && !i_in_reset && !i_rst_leave) |=>
      o_pc == $past(i_vbr) + $past(i_vec_offset)) // [RQ7]
    else $error("exception did not branch to base plus offset");
  AST_SAVE_PC: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_exc_take |=> o_saved_pc == $past(o_pc) && o_saved_status_word == $past(i_status)) // [RQ6]
    else $error("context not saved on exception");
endmodule // psm_pc_unit

// *** rtl/psm_ctrl.sv ***
// Processor state and privilege mode controller top level.
// Function
// [RQ1] A low power-on reset pin puts the device in the power-on reset state.
// [RQ2] A low manual reset pin puts the device in the manual reset state.
// [RQ3] Power-on reset initialises the CPU state and every on-chip module register.
// [RQ4] Manual reset initialises everything except the bus state controller registers.
// [RQ5] Leaving any reset sets the program counter to the fixed reset vector.
// [RQ6] Accepting an exception or interrupt saves the PC and the status word.
// [RQ7] After saving, execution branches to the vector base plus the vector offset.
// [RQ8] Exactly five processor states exist, with exception handling transient.
// [RQ9] Power-down halts execution and offers sleep and standby modes.
// [RQ10] A bus request moves the device to the bus-released state and grants the bus.
// [RQ11] The privilege bit selects user mode at 0 and privileged mode at 1.
// [RQ12] Entry to reset or exception handling forces the privilege bit to 1.
// [RQ13] Completion of exception handling clears the privilege bit to 0.
// [RQ14] Protected registers are accessible only while the privilege bit is 1.
// [RQ15] In program execution instructions are fetched and executed in order.
// [RQ16] Both resets low together is treated as a power-on reset.
module psm_ctrl
  import psm_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_power_on_reset_n,
  input  wire logic          i_manual_reset_n,
  input  wire logic          i_exc_req,
  input  wire logic [31:0]   i_vec_offset,
  input  wire logic          i_exc_done,
  input  wire logic          i_issue,
  input  wire logic          i_branch,
  input  wire logic [31:0]   i_branch_addr,
  input  wire logic          i_sleep_req,
  input  wire logic          i_standby_sel,
  input  wire logic          i_wake,
  input  wire logic          i_bus_req,
  input  wire logic          i_sr_wr,
  input  wire logic [31:0]   i_sr_wdata,
  input  wire logic          i_vbr_wr,
  input  wire logic [31:0]   i_vbr_wdata,
  input  wire logic          i_priv_access,
  output logic      [4:0]    o_state,
  output logic      [31:0]   o_pc,
  output logic               o_fetch_en,
  output logic      [31:0]   o_status_word,
  output logic               o_privilege_mode_bit,
  output logic      [31:0]   o_saved_pc,
  output logic      [31:0]   o_saved_status_word,
  output logic      [31:0]   o_vbr,
  output logic               o_init_cpu,
  output logic               o_init_modules,
  output logic               o_init_bsc,
  output logic               o_bus_grant,
  output logic               o_sleep,
  output logic               o_standby,
  output logic               o_priv_violation
);
  psm_state_t    state_r;
  psm_state_t    state_nxt;
  psm_rst_kind_t rst_kind;
  logic          in_reset;
  logic          rst_leave;
  logic          exc_take;
  logic          standby_r;
  logic          init_bsc_w;

  // One decode of the privilege bit keeps the write guards and the violation flag in step.
  function automatic logic is_privileged(input logic [31:0] sr);
    return sr[PSM_MD_BIT] == PSM_MD_PRIV;
  endfunction

  assign in_reset  = (rst_kind != PSM_RST_NONE);
  assign rst_leave = (state_r == PSM_ST_RESET) && !in_reset;
  assign exc_take  = (state_r == PSM_ST_RUN) && i_exc_req && !in_reset;

  psm_reset_arb u_arb (
    .i_clk              (i_clk),
    .i_rst_n            (i_rst_n),
    .i_power_on_reset_n (i_power_on_reset_n),
    .i_manual_reset_n   (i_manual_reset_n),
    .o_kind             (rst_kind),
    .o_init_bsc         (init_bsc_w)
  );

  // Reset entry is taken from any state so a hung bus release cannot block it.
  always_comb begin
    state_nxt = state_r;
    if (in_reset) begin
      state_nxt = PSM_ST_RESET; // [RQ1] [RQ2]
    end else begin
      unique case (state_r)
        PSM_ST_RESET: state_nxt = PSM_ST_EXC; // [RQ8]
        PSM_ST_EXC: begin
          if (i_exc_done) begin
            state_nxt = PSM_ST_RUN;
          end
        end
        PSM_ST_RUN: begin
          if (i_exc_req) begin
            state_nxt = PSM_ST_EXC; // [RQ8]
          end else if (i_bus_req) begin
            state_nxt = PSM_ST_BUSRL; // [RQ10]
          end else if (i_sleep_req) begin
            state_nxt = PSM_ST_PDN; // [RQ9]
          end
        end
        PSM_ST_BUSRL: begin
          if (!i_bus_req) begin
            state_nxt = PSM_ST_RUN;
          end
        end
        PSM_ST_PDN: begin
          if (i_wake) begin
            state_nxt = PSM_ST_EXC;
          end
        end
        default: state_nxt = PSM_ST_RESET;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r <= PSM_ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      standby_r <= 1'b0;
    end else if (state_r == PSM_ST_RUN && i_sleep_req) begin
      standby_r <= i_standby_sel; // [RQ9]
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || in_reset) begin
      o_status_word <= PSM_SR_RST; // [RQ12]
    end else if (exc_take || (state_r == PSM_ST_PDN && i_wake)) begin
      o_status_word[PSM_MD_BIT] <= PSM_MD_PRIV; // [RQ12]
    end else if (state_r == PSM_ST_EXC && i_exc_done) begin
      o_status_word <= o_saved_status_word;
      o_status_word[PSM_MD_BIT] <= PSM_MD_USER; // [RQ13]
    end else if (i_sr_wr && is_privileged(o_status_word)) begin
      o_status_word <= i_sr_wdata; // [RQ14]
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || in_reset) begin
      o_vbr <= PSM_VBR_RST; // [RQ3] [RQ4]
    end else if (i_vbr_wr && is_privileged(o_status_word)) begin
      o_vbr <= i_vbr_wdata; // [RQ14]
    end
  end

  psm_pc_unit u_pc (
    .i_clk               (i_clk),
    .i_rst_n             (i_rst_n),
    .i_in_reset          (in_reset),
    .i_exc_take          (exc_take),
    .i_rst_leave         (rst_leave),
    .i_step              (o_fetch_en && i_issue),
    .i_branch            (o_fetch_en && i_branch),
    .i_branch_addr       (i_branch_addr),
    .i_vbr               (o_vbr),
    .i_vec_offset        (i_vec_offset),
    .i_status            (o_status_word),
    .i_rte               (1'b0),
    .o_pc                (o_pc),
    .o_saved_pc          (o_saved_pc),
    .o_saved_status_word (o_saved_status_word)
  );

  assign o_state              = state_r;
  assign o_privilege_mode_bit = o_status_word[PSM_MD_BIT]; // [RQ11]
  assign o_fetch_en           = (state_r == PSM_ST_RUN) || (state_r == PSM_ST_EXC); // [RQ15]
  assign o_bus_grant          = (state_r == PSM_ST_BUSRL); // [RQ10]
  assign o_sleep              = (state_r == PSM_ST_PDN) && !standby_r; // [RQ9]
  assign o_standby            = (state_r == PSM_ST_PDN) && standby_r; // [RQ9]
  assign o_init_cpu           = in_reset; // [RQ3] [RQ4]
  assign o_init_modules       = in_reset; // [RQ3] [RQ4]
  assign o_init_bsc           = in_reset && init_bsc_w; // [RQ4]
  // A user-mode attempt is flagged rather than trapped here; the pipeline raises the trap.
  assign o_priv_violation     = (i_priv_access || i_sr_wr || i_vbr_wr) &&
                                !is_privileged(o_status_word); // [RQ14]

  sequence s_exc_entry;
    state_r == PSM_ST_RUN && i_exc_req && !in_reset;
  endsequence

  sequence s_exc_exit;
    state_r == PSM_ST_EXC && i_exc_done && !in_reset;
  endsequence

  sequence s_wake_entry;
    state_r == PSM_ST_PDN && i_wake && !in_reset;
  endsequence

  sequence s_pon_pin_low;
    !i_power_on_reset_n;
  endsequence

  sequence s_man_pin_low;
    i_power_on_reset_n && !i_manual_reset_n;
  endsequence

  sequence s_sleep_entry;
    state_r == PSM_ST_RUN && i_sleep_req && !i_exc_req && !i_bus_req && !in_reset;
  endsequence

  sequence s_bus_leave;
    state_r == PSM_ST_BUSRL && !i_bus_req && !in_reset;
  endsequence

  sequence s_plain_step;
    state_r == PSM_ST_RUN && i_issue && !i_branch && !i_exc_req && !in_reset;
  endsequence

  // A refused write is only visible when no other event rewrites the status word that cycle.
  sequence s_user_sr_write;
    i_sr_wr && !o_privilege_mode_bit && !in_reset && !exc_take &&
      !(state_r == PSM_ST_EXC && i_exc_done) && !(state_r == PSM_ST_PDN && i_wake);
  endsequence

  // The pins are seen one edge late, so the init strobes lead the state change by one cycle.
  AST_PON_RESET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_pon_pin_low |=> o_init_bsc ##1 state_r == PSM_ST_RESET) // [RQ1]
    else $error("power-on reset not entered");

  AST_MAN_RESET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_man_pin_low |=> !o_init_bsc ##1 state_r == PSM_ST_RESET) // [RQ2]
    else $error("manual reset not entered or bus controller cleared");

  AST_PON_INIT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_pon_pin_low |=> o_init_cpu && o_init_modules) // [RQ3]
    else $error("power-on reset did not initialise the core and modules");

  AST_MAN_INIT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_man_pin_low |=> o_init_cpu && o_init_modules && !o_init_bsc) // [RQ4]
    else $error("manual reset initialised the wrong set of modules");

  AST_RESET_VECTOR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rst_leave |=> o_pc == PSM_RESET_VECTOR && state_r == PSM_ST_EXC) // [RQ5]
    else $error("reset exit did not start at reset vector");

  AST_RESET_MD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    in_reset |=> o_privilege_mode_bit) // [RQ12]
    else $error("privilege bit not set in reset");

  AST_MD_SET: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_exc_entry |=> o_privilege_mode_bit && state_r == PSM_ST_EXC) // [RQ12]
    else $error("privilege bit not set on exception entry");

  AST_WAKE_MD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_wake_entry |=> o_privilege_mode_bit && state_r == PSM_ST_EXC) // [RQ12]
    else $error("privilege bit not set on wake into exception handling");

  AST_MD_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_exc_exit |=> !o_privilege_mode_bit && state_r == PSM_ST_RUN) // [RQ13]
    else $error("privilege bit not cleared at exception end");

  AST_EXC_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == PSM_ST_EXC && !i_exc_done && !in_reset) |=> state_r == PSM_ST_EXC) // [RQ8]
    else $error("exception handling left without completion");

  AST_USER_BLOCK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_vbr_wr && !o_privilege_mode_bit && !in_reset) |=> $stable(o_vbr)) // [RQ14]
    else $error("user mode wrote a protected register");

  AST_SR_USER_BLOCK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_user_sr_write |=> $stable(o_status_word)) // [RQ14]
    else $error("user mode wrote the status word");

  AST_PRIV_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_vbr_wr && o_privilege_mode_bit && !in_reset) |=> o_vbr == $past(i_vbr_wdata)) // [RQ14]
    else $error("privileged write to the vector base was lost");

  AST_VIOLATION_FLAG: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_sr_wr && !o_privilege_mode_bit) |-> o_priv_violation) // [RQ14]
    else $error("user mode status write not flagged");

  AST_BUS_GRANT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == PSM_ST_RUN && i_bus_req && !i_exc_req && !in_reset) |=>
      o_bus_grant && !o_fetch_en) // [RQ10]
    else $error("bus not released on request");

  AST_BUS_RETURN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_bus_leave |=> state_r == PSM_ST_RUN && !o_bus_grant) // [RQ10]
    else $error("bus not taken back after the request ended");

  AST_PDN_ENTRY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_sleep_entry |=> state_r == PSM_ST_PDN && o_standby == $past(i_standby_sel)) // [RQ9]
    else $error("power-down not entered in the selected mode");

  AST_PDN_HALT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state_r == PSM_ST_PDN |-> !o_fetch_en && (o_sleep ^ o_standby)) // [RQ9]
    else $error("power-down did not halt or mode ambiguous");

  AST_STEP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_plain_step |=> o_pc == $past(o_pc) + 32'h00000002) // [RQ15]
    else $error("program counter did not advance in order");

  AST_ONE_STATE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $onehot(state_r)) // [RQ8]
    else $error("processor state not one-hot");
endmodule // psm_ctrl

// *** verif/psm_bus_model.sv ***
// Model of an outside bus requester facing the controller.
module psm_bus_model (
  input  wire logic i_clk,
  input  wire logic i_go,
  input  wire logic i_bus_grant,
  output logic      o_bus_req
);
  timeunit 1ns;
  timeprecision 1ns;

  // The request is held until four falling edges after the grant is seen at a rising edge, because the controller
  // may take several cycles to hand the bus over.
  initial begin
    o_bus_req = 1'b0;
    forever begin
      @(posedge i_go);
      @(negedge i_clk);
      o_bus_req = 1'b1;
      repeat (20) begin
        @(posedge i_clk);
        if (i_bus_grant === 1'b1) break;
      end
      repeat (4) @(negedge i_clk);
      o_bus_req = 1'b0;
    end
  end
endmodule // psm_bus_model

// *** verif/test_psm_ctrl.sv ***
// Self-checking testbench for the processor state and mode controller.
module test_psm_ctrl
  import psm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'b0, rst_n = 1'b0, por_n = 1'b1, mr_n = 1'b1, go = 1'b0;
  logic        exc_req = 1'b0, exc_done = 1'b0, issue = 1'b0, branch = 1'b0;
  logic        sleep_req = 1'b0, standby_sel = 1'b0, wake = 1'b0, sr_wr = 1'b0;
  logic        vbr_wr = 1'b0, priv_access = 1'b0, bus_req;
  logic [31:0] vec_offset = 32'h0, branch_addr = 32'h0, sr_wdata = 32'h0, vbr_wdata = 32'h0;
  logic [4:0]  state;
  logic [31:0] pc, status_word, saved_pc, saved_sr, vbr;
  logic        fetch_en, md, init_cpu, init_modules, init_bsc, bus_grant, sleep, standby, viol;
  int          miscompares = 0;
  int          compares = 0;

  always #25 clk = ~clk;

  psm_ctrl i_psm_ctrl (
    .i_clk(clk), .i_rst_n(rst_n), .i_power_on_reset_n(por_n), .i_manual_reset_n(mr_n),
    .i_exc_req(exc_req), .i_vec_offset(vec_offset), .i_exc_done(exc_done),
    .i_issue(issue), .i_branch(branch), .i_branch_addr(branch_addr),
    .i_sleep_req(sleep_req), .i_standby_sel(standby_sel), .i_wake(wake),
    .i_bus_req(bus_req), .i_sr_wr(sr_wr), .i_sr_wdata(sr_wdata), .i_vbr_wr(vbr_wr),
    .i_vbr_wdata(vbr_wdata), .i_priv_access(priv_access), .o_state(state), .o_pc(pc),
    .o_fetch_en(fetch_en), .o_status_word(status_word), .o_privilege_mode_bit(md),
    .o_saved_pc(saved_pc), .o_saved_status_word(saved_sr), .o_vbr(vbr),
    .o_init_cpu(init_cpu), .o_init_modules(init_modules), .o_init_bsc(init_bsc),
    .o_bus_grant(bus_grant), .o_sleep(sleep), .o_standby(standby),
    .o_priv_violation(viol)
  );

  psm_bus_model i_psm_bus_model (
    .i_clk(clk), .i_go(go), .i_bus_grant(bus_grant), .o_bus_req(bus_req)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic end_of_test;
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic done_pulse;
    exc_done = 1'b1;
    cyc(1);
    exc_done = 1'b0;
    chk(state, PSM_ST_RUN);
    chk(md, PSM_MD_USER);
  endtask

  // Leaving reset must pass through exception handling at the fixed vector.
  task automatic t_boot;
    cyc(3);
    chk(state, PSM_ST_EXC);
    chk(pc, PSM_RESET_VECTOR);
    chk(md, PSM_MD_PRIV);
    chk(status_word[PSM_MD_BIT], PSM_MD_PRIV);
    vbr_wr = 1'b1;
    vbr_wdata = 32'h00001000;
    cyc(1);
    vbr_wr = 1'b0;
    chk(vbr, 32'h00001000);
    done_pulse;
  endtask

  // User-mode writes to the status word and the vector base must both be refused.
  task automatic t_run;
    branch = 1'b1;
    branch_addr = 32'h00000400;
    cyc(1);
    branch = 1'b0;
    issue = 1'b1;
    cyc(2);
    issue = 1'b0;
    chk(pc, 32'h00000404);
    sr_wr = 1'b1;
    sr_wdata = 32'h700000f0;
    vbr_wr = 1'b1;
    vbr_wdata = 32'h0000beef;
    cyc(1);
    chk(viol, 1'b1);
    chk(vbr, 32'h00001000);
    chk(status_word, 32'h00000000);
    sr_wr = 1'b0;
    vbr_wr = 1'b0;
    priv_access = 1'b1;
    cyc(1);
    chk(viol, 1'b1);
    priv_access = 1'b0;
    cyc(1);
    chk(viol, 1'b0);
    chk(md, PSM_MD_USER);
  endtask

  // A request held into the exception state must be ignored there.
  task automatic t_exc;
    exc_req = 1'b1;
    vec_offset = 32'h00000100;
    cyc(1);
    chk(state, PSM_ST_EXC);
    chk(pc, 32'h00001100);
    chk(saved_pc, 32'h00000404);
    chk(saved_sr[PSM_MD_BIT], PSM_MD_USER);
    chk(md, PSM_MD_PRIV);
    vec_offset = 32'h00000200;
    cyc(1);
    exc_req = 1'b0;
    chk(state, PSM_ST_EXC);
    chk(pc, 32'h00001100);
    chk(saved_pc, 32'h00000404);
    done_pulse;
  endtask

  task automatic t_pdn;
    for (int m = 0; m < 2; m++) begin
      branch = 1'b1;
      branch_addr = 32'h00002000;
      cyc(1);
      branch = 1'b0;
      standby_sel = m[0];
      sleep_req = 1'b1;
      cyc(1);
      sleep_req = 1'b0;
      issue = 1'b1;
      cyc(2);
      issue = 1'b0;
      chk(state, PSM_ST_PDN);
      chk({sleep, standby, fetch_en}, {~m[0], m[0], 1'b0});
      chk(pc, 32'h00002000);
      wake = 1'b1;
      cyc(1);
      wake = 1'b0;
      chk(state, PSM_ST_EXC);
      chk(md, PSM_MD_PRIV);
      done_pulse;
    end
  endtask

  task automatic t_bus;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    cyc(2);
    chk(bus_grant, 1'b1);
    chk(state, PSM_ST_BUSRL);
    chk(fetch_en, 1'b0);
    for (int k = 0; k < 20 && bus_req; k++) cyc(1);
    cyc(1);
    chk(state, PSM_ST_RUN);
  endtask

  // Manual only, power-on only, then both pins together.
  task automatic t_pins;
    logic [1:0] pins [3];
    pins = '{2'b10, 2'b01, 2'b00};
    for (int k = 0; k < 3; k++) begin
      {por_n, mr_n} = pins[k];
      cyc(3);
      chk(state, PSM_ST_RESET);
      chk({init_cpu, init_modules, init_bsc}, {2'b11, ~pins[k][1]});
      chk(md, PSM_MD_PRIV);
      {por_n, mr_n} = 2'b11;
      t_boot;
    end
  endtask

  initial begin
    cyc(8);
    chk(state, PSM_ST_RESET);
    rst_n = 1'b1;
    t_boot;
    t_run;
    t_exc;
    t_pdn;
    t_bus;
    t_pins;
    end_of_test;
  end

  // The whole sequence needs well under a hundred cycles; this margin only catches a hang.
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    end_of_test;
  end
endmodule // test_psm_ctrl
